// ===== bench/dcw_master.sv
// Fieldbus master model that writes command words into the decoder.
`timescale 1ns/1ps
module dcw_master (
  input wire logic i_clk,
  output logic o_wr,
  output logic [15:0] o_wdata
);
  // ==========================================
  // Command word writes
  initial begin
    o_wr = 1'b0;
    o_wdata = 16'h0000;
  end
  // one command, then the caller waits for the outcome.
  // reserved bits go out as given, so a test may break that on purpose.
  // The data lines are inverted once released, so stale data is never mistaken for valid.
  task automatic send(input logic [15:0] w, input int gap = 0);
    repeat (gap) @(posedge i_clk);
    @(posedge i_clk);
    o_wr <= 1'b1;
    o_wdata <= w;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_wdata <= ~w;
  endtask
  // state is decided from a masked state word, never from single bits.
  function automatic logic state_is(input logic [15:0] sw, input logic [15:0] mask,
    input logic [15:0] value);
    return (sw & mask) == value;
  endfunction
endmodule

// ===== bench/drive_command_word_decoder_bench.sv
// Self-checking bench for the drive command word decoder.
`timescale 1ns/1ps
module drive_command_word_decoder_bench;
  import dcw_pkg::*;
  logic i_clk, i_rst, wr, hdone;
  logic [15:0] wdata, rdata;
  logic [7:0] mode, eset, ecause, pend;
  dcw_cmd_t cmd;
  logic flt, nj, imm, rel, pph, goal, hs, hp, ien, iack, vh;
  int num_errors = 0;
  int compares = 0;
  dcw_master m (.i_clk(i_clk), .o_wr(wr), .o_wdata(wdata));
  dcw_decoder dut (.i_clk(i_clk), .i_rst(i_rst), .i_wr(wr), .i_wdata(wdata),
    .i_operating_mode_select(mode), .i_err_set(eset), .i_err_cause(ecause),
    .i_move_busy(1'b0), .i_halt_done(hdone), .o_rdata(rdata), .o_state_cmd(cmd),
    .o_fault_reset(flt), .o_err_pending(pend), .o_new_job(nj), .o_job_immediate(imm),
    .o_job_relative(rel), .o_pp_halt(pph), .o_goal_arrived(goal), .o_homing_start(hs),
    .o_homing_stop(hp), .o_interp_enable(ien), .o_interp_active_ack(iack),
    .o_vel_halt(vh));
  // ==========================================
  // Helpers
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic put(input logic [15:0] w);
    m.send(w);
    #1;
  endtask
  task automatic wrap_up;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic state_cmds;
    logic [15:0] w [6] = '{16'h0006, 16'h000F, 16'h0007, 16'h0005, 16'h008B, 16'h0086};
    dcw_cmd_t e [6] = '{DCW_CMD_SHUTDOWN, DCW_CMD_ENABLE_OP, DCW_CMD_DISABLE_OP,
      DCW_CMD_DISABLE_VOLTAGE, DCW_CMD_QUICK_STOP, DCW_CMD_SHUTDOWN};
    for (int i = 0; i < 6; i++) begin
      put(w[i]);
      chk("state_cmd", 16'(e[i]), 16'(cmd));
    end
    put(16'hFE06);
    chk("rdata", 16'h0006, rdata);
  endtask
  task automatic fault_ack;
    @(posedge i_clk) eset <= 8'h03;
    ecause <= 8'h02;
    @(posedge i_clk) eset <= 8'h00;
    put(16'h0080);
    chk("fault_reset", 1, flt);
    @(posedge i_clk) ecause <= 8'h00;
    #1;
    chk("err_pending", 16'h0002, pend);
    put(16'h0080);
    chk("fault_reset", 0, flt);
    put(16'h0000);
    put(16'h0080);
    chk("fault_reset", 1, flt);
    put(16'h0000);
    chk("err_pending", 0, pend);
  endtask
  task automatic pp_mode;
    @(posedge i_clk) mode <= DCW_MODE_PROFILE_POS;
    put(16'h0070);
    chk("new_job", 1, nj);
    chk("immediate", 1, imm);
    chk("relative", 1, rel);
    put(16'h0150);
    chk("immediate", 0, imm);
    @(posedge i_clk);
    #1;
    chk("pp_halt", 1, pph);
    @(posedge i_clk) hdone <= 1'b1;
    @(posedge i_clk) hdone <= 1'b0;
    #1;
    chk("goal", 1, goal);
    put(16'h0050);
    chk("goal", 1, goal);
    chk("pp_halt", 0, pph);
  endtask
  task automatic other_modes;
    @(posedge i_clk) mode <= DCW_MODE_HOMING;
    put(16'h0000);
    put(16'h0010);
    chk("homing_start", 1, hs);
    put(16'h0000);
    chk("homing_stop", 1, hp);
    @(posedge i_clk) mode <= DCW_MODE_INTERP;
    put(16'h0010);
    chk("interp_ack", 1, iack & ien);
    chk("new_job", 0, nj);
    put(16'h0000);
    chk("interp_ack", 0, iack);
    @(posedge i_clk) mode <= DCW_MODE_PROFILE_VEL;
    put(16'h0100);
    chk("vel_halt", 1, vh);
    chk("pp_halt", 0, pph);
    put(16'h0000);
    chk("vel_halt", 0, vh);
  endtask
  // ==========================================
  // Main sequence and hang guard
  initial begin
    i_rst = 1'b1;
    mode = 8'h00;
    eset = 8'h00;
    ecause = 8'h00;
    hdone = 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    chk("reset_cmd", 16'(DCW_CMD_DISABLE_VOLTAGE), 16'(cmd));
    state_cmds();
    fault_ack();
    pp_mode();
    other_modes();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    num_errors++;
    wrap_up();
  end
endmodule

// ===== rtl/dcw_decoder.sv
// Drive command word decoder: state commands, fault reset and mode bits.
// Functional notes
// - Bits 2..0 of 110 give shutdown, 111 give switch on (reported as disable or enable operation by bit 3), and bit 1 low gives disable voltage.
// - Bit 2 low with bit 1 high gives quick stop; bits 3..0 of 0111 and 1111 give disable and enable operation.
// - Bits 4, 5, 6 and 8 take their meaning from the selected operating mode.
// - Fault reset is made only by a rising edge of bit 7, never by its steady level.
// - In interpolated mode data sets are evaluated only while bit 4 is set, shown by an ack bit.
// - In profile position mode bit 5 set replaces the running move at once, clear queues it.
// - In profile position mode bit 6 set makes the new move relative to the setpoint.
// - In profile position mode setting bit 8 aborts the move with the ramp-down rate.
// - After that halt completes the goal-arrived flag is set and clearing bit 8 does nothing.
// - In profile velocity mode bit 8 brakes to zero speed and clearing it accelerates again.
`timescale 1ns/1ps
module dcw_decoder (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wr,
  input wire logic [15:0] i_wdata,
  input wire logic [7:0] i_operating_mode_select,
  input wire logic [dcw_pkg::DCW_NUM_ERR-1:0] i_err_set,
  input wire logic [dcw_pkg::DCW_NUM_ERR-1:0] i_err_cause,
  input wire logic i_move_busy,
  input wire logic i_halt_done,
  output logic [15:0] o_rdata,
  output dcw_pkg::dcw_cmd_t o_state_cmd,
  output logic o_fault_reset,
  output logic [dcw_pkg::DCW_NUM_ERR-1:0] o_err_pending,
  output logic o_new_job,
  output logic o_job_immediate,
  output logic o_job_relative,
  output logic o_pp_halt,
  output logic o_goal_arrived,
  output logic o_homing_start,
  output logic o_homing_stop,
  output logic o_interp_enable,
  output logic o_interp_active_ack,
  output logic o_vel_halt
);
  import dcw_pkg::*;

  // ==========================================================
  // Command word register and edge history
  logic [15:0] cmd_word;
  logic [15:0] next_cmd_word;
  logic prev_b4;
  logic prev_b7;
  logic prev_b8;
  logic [DCW_NUM_ERR-1:0] err;
  logic [DCW_NUM_ERR-1:0] next_err;
  logic goal;
  logic next_goal;
  logic halted;
  logic next_halted;
  dcw_cmd_t cmd;
  logic rise4;
  logic fall4;
  logic rise7;
  logic rise8;
  logic pp;
  logic hm;
  logic ip;
  logic pv;

  always_comb begin
    next_cmd_word = cmd_word;
    if (i_wr) begin
      next_cmd_word = i_wdata & DCW_USED_MASK;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cmd_word <= DCW_CMD_WORD_RESET;
      prev_b4 <= 1'b0;
      prev_b7 <= 1'b0;
      prev_b8 <= 1'b0;
    end else begin
      cmd_word <= next_cmd_word;
      prev_b4 <= cmd_word[DCW_BIT_MODE4];
      prev_b7 <= cmd_word[DCW_BIT_FAULT_RST];
      prev_b8 <= cmd_word[DCW_BIT_HALT];
    end
  end

  assign o_rdata = cmd_word;

  // ==========================================================
  // State command decode
  always_comb begin
    cmd = DCW_CMD_NONE;
    if (!cmd_word[DCW_BIT_VOLTAGE]) begin
      cmd = DCW_CMD_DISABLE_VOLTAGE;
    end else if (!cmd_word[DCW_BIT_QSTOP_N]) begin
      cmd = DCW_CMD_QUICK_STOP;
    end else if (cmd_word[DCW_BIT_QSTOP_N:DCW_BIT_SWITCH_ON] == DCW_PAT_SHUTDOWN) begin
      cmd = DCW_CMD_SHUTDOWN;
    end else if (cmd_word[DCW_BIT_ENABLE_OP:DCW_BIT_SWITCH_ON] == DCW_PAT_EN_OP) begin
      cmd = DCW_CMD_ENABLE_OP;
    end else if (cmd_word[DCW_BIT_ENABLE_OP:DCW_BIT_SWITCH_ON] == DCW_PAT_DIS_OP) begin
      cmd = DCW_CMD_DISABLE_OP;
    end
  end
  // Switch on is the same pattern as disable operation; the state machine downstream
  // tells them apart by its current state, so only disable operation is reported.
  assign o_state_cmd = cmd;

  // ==========================================================
  // Mode-dependent bits
  // mode selects meaning.
  assign pp = (i_operating_mode_select == DCW_MODE_PROFILE_POS);
  assign hm = (i_operating_mode_select == DCW_MODE_HOMING);
  assign ip = (i_operating_mode_select == DCW_MODE_INTERP);
  assign pv = (i_operating_mode_select == DCW_MODE_PROFILE_VEL);
  assign rise4 = cmd_word[DCW_BIT_MODE4] && !prev_b4;
  assign fall4 = !cmd_word[DCW_BIT_MODE4] && prev_b4;
  assign rise7 = cmd_word[DCW_BIT_FAULT_RST] && !prev_b7;
  assign rise8 = cmd_word[DCW_BIT_HALT] && !prev_b8;

  assign o_fault_reset = rise7;
  assign o_new_job = pp && rise4;
  assign o_job_immediate = pp && cmd_word[DCW_BIT_IMMEDIATE];
  assign o_job_relative = pp && cmd_word[DCW_BIT_RELATIVE];
  // halt aborts the move.
  // The latched halt drives this, so dropping bit 8 mid-brake cannot cut the ramp short.
  assign o_pp_halt = pp && halted;
  assign o_homing_start = hm && rise4;
  assign o_homing_stop = hm && fall4;
  assign o_interp_enable = ip && cmd_word[DCW_BIT_MODE4];
  assign o_interp_active_ack = o_interp_enable;
  assign o_vel_halt = pv && cmd_word[DCW_BIT_HALT];

  // ==========================================================
  // Error acknowledge and halt tracking
  always_comb begin
    next_err = err;
    next_goal = goal;
    next_halted = halted;
    // clear only errors whose cause is gone; a new error wins.
    if (rise7) begin
      next_err = err & i_err_cause;
    end
    next_err = next_err | i_err_set;
    // halt is latched until it completes; a released bit does not cancel it.
    if (pp && rise8) begin
      next_halted = 1'b1;
      next_goal = 1'b0;
    end else if (o_new_job) begin
      next_goal = 1'b0;
    end
    if (halted && i_halt_done) begin
      next_goal = 1'b1;
      next_halted = 1'b0;
    end
    if (!i_move_busy && !halted && o_new_job) begin
      next_goal = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      err <= '0;
      goal <= 1'b0;
      halted <= 1'b0;
    end else begin
      err <= next_err;
      goal <= next_goal;
      halted <= next_halted;
    end
  end

  assign o_err_pending = err;
  assign o_goal_arrived = goal;

  // ==========================================================
  // Assertions
  // rising edge makes one pulse.
  a_fault_reset_pulse: assert property (@(posedge i_clk) disable iff (i_rst)
    o_fault_reset |=> !o_fault_reset)
    else $error("fault reset not a single pulse");
  a_fault_level_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
    ($stable(cmd_word[DCW_BIT_FAULT_RST]) && $past(prev_b7) == cmd_word[DCW_BIT_FAULT_RST])
    |-> !o_fault_reset)
    else $error("fault reset on steady level");
  a_fault_reset_rise: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(cmd_word[DCW_BIT_FAULT_RST]) |-> o_fault_reset)
    else $error("fault reset missed on rising bit");
  // error with cause present survives the reset edge.
  a_err_kept: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_fault_reset && err[0] && i_err_cause[0]) |=> err[0])
    else $error("error cleared while cause present");
  a_err_cleared: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_fault_reset && !i_err_cause[0] && !i_err_set[0]) |=> !err[0])
    else $error("error not cleared");
  a_err_set_wins: assert property (@(posedge i_clk) disable iff (i_rst)
    (|i_err_set) |=> (o_err_pending & $past(i_err_set)) == $past(i_err_set))
    else $error("new error not latched");
  a_err_held: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_fault_reset |=> (o_err_pending & $past(o_err_pending)) == $past(o_err_pending))
    else $error("error cleared without fault reset");
  // disable voltage on bit 1 low.
  a_disable_voltage: assert property (@(posedge i_clk) disable iff (i_rst)
    !cmd_word[DCW_BIT_VOLTAGE] |-> o_state_cmd == DCW_CMD_DISABLE_VOLTAGE)
    else $error("disable voltage not decoded");
  a_shutdown_decode: assert property (@(posedge i_clk) disable iff (i_rst)
    (cmd_word[DCW_BIT_QSTOP_N:DCW_BIT_SWITCH_ON] == DCW_PAT_SHUTDOWN)
    |-> o_state_cmd == DCW_CMD_SHUTDOWN)
    else $error("shutdown not decoded");
  a_enable_op: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_wr && (i_wdata[3:0] == DCW_PAT_EN_OP)) |=> o_state_cmd == DCW_CMD_ENABLE_OP)
    else $error("enable operation not decoded");
  a_quick_stop: assert property (@(posedge i_clk) disable iff (i_rst)
    (cmd_word[DCW_BIT_VOLTAGE] && !cmd_word[DCW_BIT_QSTOP_N])
    |-> o_state_cmd == DCW_CMD_QUICK_STOP)
    else $error("quick stop not decoded");
  a_disable_op: assert property (@(posedge i_clk) disable iff (i_rst)
    (cmd_word[DCW_BIT_ENABLE_OP:DCW_BIT_SWITCH_ON] == DCW_PAT_DIS_OP)
    |-> o_state_cmd == DCW_CMD_DISABLE_OP)
    else $error("disable operation not decoded");
  a_pp_bits_idle: assert property (@(posedge i_clk) disable iff (i_rst)
    !pp |-> !(o_new_job || o_job_immediate || o_job_relative || o_pp_halt))
    else $error("position output outside profile position mode");
  // rising bit 4 requests a job.
  a_new_job_edge: assert property (@(posedge i_clk) disable iff (i_rst)
    (pp && $rose(cmd_word[DCW_BIT_MODE4])) |-> o_new_job)
    else $error("new job not requested");
  // homing start in the cycle the bit rises, low again one cycle later.
  a_homing_start: assert property (@(posedge i_clk) disable iff (i_rst)
    (hm && cmd_word[DCW_BIT_MODE4] && !prev_b4) |-> o_homing_start ##1 !o_homing_start)
    else $error("homing start wrong");
  a_homing_stop: assert property (@(posedge i_clk) disable iff (i_rst)
    (hm && $fell(cmd_word[DCW_BIT_MODE4])) |-> o_homing_stop)
    else $error("homing stop missed");
  a_job_immediate: assert property (@(posedge i_clk) disable iff (i_rst)
    (pp && cmd_word[DCW_BIT_IMMEDIATE]) |-> o_job_immediate)
    else $error("immediate replacement not flagged");
  a_halt_latch: assert property (@(posedge i_clk) disable iff (i_rst)
    (pp && $rose(cmd_word[DCW_BIT_HALT]) && !(halted && i_halt_done)) |=> halted)
    else $error("halt request not latched");
  a_goal_after_halt: assert property (@(posedge i_clk) disable iff (i_rst)
    (halted && i_halt_done) |=> o_goal_arrived && !halted)
    else $error("goal not set after halt");
  a_goal_held: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_goal_arrived && !o_new_job && !(pp && $rose(cmd_word[DCW_BIT_HALT])))
    |=> o_goal_arrived)
    else $error("goal flag lost");
  // ack only in interpolated mode with bit 4.
  a_interp_ack: assert property (@(posedge i_clk) disable iff (i_rst)
    o_interp_active_ack |-> ip && cmd_word[DCW_BIT_MODE4])
    else $error("interpolation ack without enable");
  // enable and ack follow bit 4.
  a_interp_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    (ip && cmd_word[DCW_BIT_MODE4]) |-> (o_interp_enable && o_interp_active_ack))
    else $error("interpolation not enabled");
  a_vel_halt: assert property (@(posedge i_clk) disable iff (i_rst)
    pv |-> (o_vel_halt == cmd_word[DCW_BIT_HALT]))
    else $error("velocity halt does not follow bit 8");
  a_reserved_zero: assert property (@(posedge i_clk) disable iff (i_rst)
    i_wr |=> o_rdata[15:9] == 7'h00)
    else $error("reserved bits stored");
  a_write_stored: assert property (@(posedge i_clk) disable iff (i_rst)
    i_wr |=> o_rdata == ($past(i_wdata) & DCW_USED_MASK))
    else $error("written word not stored");

  c_fault_reset: cover property (@(posedge i_clk) disable iff (i_rst) o_fault_reset);
  c_new_job: cover property (@(posedge i_clk) disable iff (i_rst) o_new_job);
  c_halt_goal: cover property (@(posedge i_clk) disable iff (i_rst) halted ##1 o_goal_arrived);
  c_homing_stop: cover property (@(posedge i_clk) disable iff (i_rst) o_homing_stop);
  c_interp_ack: cover property (@(posedge i_clk) disable iff (i_rst) o_interp_active_ack);
endmodule

// ===== rtl/dcw_pkg.sv
// Package with constants and types for the drive command word decoder.
package dcw_pkg;
  // ==========================================================
  // Register and field layout
  localparam logic [15:0] DCW_CMD_WORD_INDEX = 16'h6040;
  localparam logic [15:0] DCW_CMD_WORD_RESET = 16'h0000;
  localparam int DCW_BIT_SWITCH_ON = 0;
  localparam int DCW_BIT_VOLTAGE = 1;
  localparam int DCW_BIT_QSTOP_N = 2;
  localparam int DCW_BIT_ENABLE_OP = 3;
  localparam int DCW_BIT_MODE4 = 4;
  localparam int DCW_BIT_IMMEDIATE = 5;
  localparam int DCW_BIT_RELATIVE = 6;
  localparam int DCW_BIT_FAULT_RST = 7;
  localparam int DCW_BIT_HALT = 8;
  localparam logic [15:0] DCW_USED_MASK = 16'h01FF;
  localparam logic [2:0] DCW_PAT_SHUTDOWN = 3'h6;
  localparam logic [2:0] DCW_PAT_SWITCH_ON = 3'h7;
  localparam logic [3:0] DCW_PAT_DIS_OP = 4'h7;
  localparam logic [3:0] DCW_PAT_EN_OP = 4'hF;
  localparam int DCW_NUM_ERR = 8;
  // ==========================================================
  // Operating mode select encodings
  localparam logic [7:0] DCW_MODE_PROFILE_POS = 8'h01;
  localparam logic [7:0] DCW_MODE_PROFILE_VEL = 8'h03;
  localparam logic [7:0] DCW_MODE_HOMING = 8'h06;
  localparam logic [7:0] DCW_MODE_INTERP = 8'h07;
  // ==========================================================
  // Decoded state command
  typedef enum {
    DCW_CMD_NONE,
    DCW_CMD_SHUTDOWN,
    DCW_CMD_SWITCH_ON,
    DCW_CMD_DISABLE_VOLTAGE,
    DCW_CMD_QUICK_STOP,
    DCW_CMD_DISABLE_OP,
    DCW_CMD_ENABLE_OP
  } dcw_cmd_t;
endpackage
